// File: host_bridge_asserts.sv
// concurrent checks on the config/error bank ports
// assumes the top module port names; bound at the foot of this file
`timescale 1ns/1ps

module host_bridge_asserts
   import host_bridge_pkg::*;
(
   // clock, reset, apb
   input wire logic              clk, rst_b, ce, psel, penable, pwrite, pready, pslverr,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata, prdata,
   // side logic
   input wire logic              fsb_stop_grant, stop_grant_ack, clk_sync_done,
   input wire logic              route_valid, route_to_graphics, serr_global_enable, serr_msg,
   input wire logic [3:0]        queue_depth,
   input wire logic [1:0]        mem_io_mult,
   input wire mem_rate_t         mem_rate,
   input wire bridge_control_t   bridge_control,
   input wire cpu_req_t          cpu_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // shadow of the writable routing and stop-grant fields
   logic [2:0] sgc_h;
   logic       mono_h;
   wire logic  cfg_wr = psel && penable && pwrite && pready && paddr == HUB_CFG_ADDR;
   wire logic  mem_q  = ce && cpu_req.valid && !cpu_req.is_io;
   wire logic  mono_m = cpu_req.addr inside {[MONO_MEM_LO:MONO_MEM_HI]};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sgc_h  <= 3'h0;
         mono_h <= 1'b0;
      end else if (cfg_wr) begin
         sgc_h  <= pwdata[15:13];
         mono_h <= pwdata[5];
      end
   end

   io_mult_a: assert property (mem_io_mult == MEM_IO_MULT)
      else $error("memory io multiple wrong");
   ack_single_a: assert property (ce && fsb_stop_grant && sgc_h != SGC_TWO |=> stop_grant_ack)
      else $error("stop grant ack missing");
   ack_cause_a: assert property (stop_grant_ack |-> $past(fsb_stop_grant))
      else $error("stop grant ack without grant");
   rate_hold_a: assert property ($changed(mem_rate) |-> $past(clk_sync_done, 2))
      else $error("memory rate moved without sync");
   vga_off_a: assert property (mem_q && !bridge_control.vga_enable |=> !route_to_graphics)
      else $error("memory routed to graphics with vga off");
   mono_gfx_a: assert property (mem_q && bridge_control.vga_enable && !mono_h && mono_m
      |=> route_to_graphics)
      else $error("mono memory not sent to graphics");
   mono_hub_a: assert property (mem_q && bridge_control.vga_enable && mono_h && mono_m
      |=> !route_to_graphics)
      else $error("mono memory not sent to hub");
   route_valid_a: assert property (ce && cpu_req.valid |=> route_valid)
      else $error("route result missing");
   serr_en_a: assert property (serr_msg |-> $past(serr_global_enable))
      else $error("error message while disabled");
   depth_val_a: assert property (queue_depth == IOQ_SHALLOW || queue_depth == IOQ_DEEP)
      else $error("queue depth out of range");
   upper_zero_a: assert property (psel && !penable && ce |=> prdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
endmodule : host_bridge_asserts

bind host_bridge_config_and_error_status host_bridge_asserts u_chk (.*);

// File: host_bridge_config_and_error_status.sv
// hub configuration and error status registers with their side logic
// assumes an APB master on clk; straps and events are synchronous to clk
//
// Function
// - stop-grant count 000 acks after one stop grant, 001 after two
// - stop grants from every thread of every processor count toward total
// - memory select resets to 00 and with bus strap picks memory rate
// - memory I/O clock always runs at twice memory clock
// - new memory select applies only after clock synchronization completes
// - VGA and mono-present both clear sends compatibility references to hub, except 3BC-3BF
// - VGA set, mono clear: VGA to graphics, port 3BF and aliases to hub
// - both set: VGA references to graphics, mono references to hub
// - mono decode is B0000-B7FFF and six ports, ignoring A15:10
// - with VGA and mono-present set, any I/O touching a mono port goes to the hub link
// - VGA clear: 3BC-3BF decode as ordinary I/O against bridge window
// - bit 3 shows graphics mode strap sampled at power good
// - bit 2 shows queue depth strap: 0 means depth 1, 1 depth 12
// - bits 1:0 latch bus speed strap on power good rising edge
// - flags set always; system error message only on enabled rise
// - error flags clear only by writing one
// - bit 9 flags locked access to non-memory space
// - bit 8 flags management interrupt from software trigger
// - multi-bit error sets bit 7, logs, locks log until cleared
// - single-bit error sets bit 0, logs once; multi-bit still overwrites
// - bits 5..1 flag hub special cycle and graphics access faults
`timescale 1ns/1ps

module host_bridge_config_and_error_status (
   // clock, reset, enable
   input  wire logic                                clk,
   input  wire logic                                rst_b,
   input  wire logic                                ce,
   // apb slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [host_bridge_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // straps
   input  wire logic                                power_good,
   input  wire host_bridge_pkg::straps_t            straps,
   output logic      [3:0]                          queue_depth,
   // stop grant
   input  wire logic                                fsb_stop_grant,
   output logic                                     stop_grant_ack,
   // memory clocking
   input  wire logic                                clk_sync_done,
   output host_bridge_pkg::mem_rate_t               mem_rate,
   output logic      [1:0]                          mem_io_mult,
   // compatibility routing
   input  wire host_bridge_pkg::bridge_control_t    bridge_control,
   input  wire host_bridge_pkg::cpu_req_t           cpu_req,
   output logic                                     route_valid,
   output logic                                     route_to_graphics,
   // errors
   input  wire host_bridge_pkg::err_event_t         err_event,
   input  wire host_bridge_pkg::ecc_report_t        ecc_report,
   input  wire logic [15:0]                         error_command,
   input  wire logic                                serr_global_enable,
   output logic                                     serr_msg,
   output host_bridge_pkg::err_log_t                error_address_log
);
   import host_bridge_pkg::*;

   logic [2:0]  stop_grant_count_reg;
   logic [1:0]  mem_freq_select_reg;
   logic [1:0]  mem_freq_active_reg;
   logic        mono_adapter_present_reg;
   straps_t     strap_reg;
   logic        power_good_reg;
   logic [15:0] err_flags_reg;
   logic [15:0] err_flags_next;
   logic [1:0]  sg_seen_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [3:0]  queue_depth_reg;
   mem_rate_t   mem_rate_reg;
   logic        serr_msg_reg;
   logic        route_valid_reg;
   logic        route_gfx_reg;
   err_log_t    log_reg;

   logic        setup_phase;
   logic        wr_access;
   logic        hit_cfg;
   logic        hit_err;
   logic [15:0] hub_cfg_view;
   logic [15:0] err_events;
   logic [15:0] err_clear;
   logic [15:0] err_rise;

   assign setup_phase = ce && psel && !penable;
   assign wr_access   = ce && psel && penable && pwrite;
   assign hit_cfg     = (paddr == HUB_CFG_ADDR);
   assign hit_err     = (paddr == ERR_STS_ADDR);

   // unused positions stay zero, so reserved bits read back as zero
   always_comb begin
      hub_cfg_view                  = 16'h0000;
      hub_cfg_view[SGC_HI:SGC_LO]   = stop_grant_count_reg;
      hub_cfg_view[MFS_HI:MFS_LO]   = mem_freq_select_reg;
      hub_cfg_view[MONO_BIT]        = mono_adapter_present_reg;
      hub_cfg_view[GMODE_BIT]       = strap_reg.graphics_mode_strap;
      hub_cfg_view[IOQ_BIT]         = strap_reg.queue_depth_pin;
      hub_cfg_view[FBF_HI:FBF_LO]   = strap_reg.bus_speed_strap;
   end

   // read data and error captured in the setup cycle; ready whenever enabled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (setup_phase) begin
         pslverr_reg <= !(hit_cfg || hit_err);
         if (hit_cfg) begin
            prdata_reg <= {16'h0000, hub_cfg_view};
         end else if (hit_err) begin
            prdata_reg <= {16'h0000, err_flags_reg};
         end else begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready  = ce;

   // software-written configuration fields
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stop_grant_count_reg     <= HUB_CFG_RESET[SGC_HI:SGC_LO];
         mem_freq_select_reg      <= HUB_CFG_RESET[MFS_HI:MFS_LO];
         mono_adapter_present_reg <= HUB_CFG_RESET[MONO_BIT];
      end else if (wr_access && hit_cfg) begin
         stop_grant_count_reg     <= pwdata[SGC_HI:SGC_LO] & HUB_CFG_WMASK[SGC_HI:SGC_LO];
         mem_freq_select_reg      <= pwdata[MFS_HI:MFS_LO] & HUB_CFG_WMASK[MFS_HI:MFS_LO];
         mono_adapter_present_reg <= pwdata[MONO_BIT];
      end
   end

   // straps caught on the rising edge of power good, never under reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_good_reg  <= 1'b0;
         strap_reg       <= '0;
         queue_depth_reg <= IOQ_SHALLOW;
      end else if (ce) begin
         power_good_reg <= power_good;
         if (power_good && !power_good_reg) begin
            strap_reg       <= straps;
            queue_depth_reg <= straps.queue_depth_pin ? IOQ_DEEP : IOQ_SHALLOW;
         end
      end
   end

   assign queue_depth = queue_depth_reg;

   // stop-grant counting; reserved codes behave as a single grant.
   // changing the count mid-sequence is software's fault and is not guarded.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sg_seen_reg    <= 2'h0;
         stop_grant_ack <= 1'b0;
      end else if (ce) begin
         stop_grant_ack <= 1'b0;
         if (fsb_stop_grant) begin
            if (stop_grant_count_reg == SGC_TWO && sg_seen_reg == 2'h0) begin
               sg_seen_reg <= 2'h1;
            end else begin
               sg_seen_reg    <= 2'h0;
               stop_grant_ack <= 1'b1;
            end
         end
      end
   end

   // memory timing held until the synchronization sequence finishes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_freq_active_reg <= HUB_CFG_RESET[MFS_HI:MFS_LO];
         mem_rate_reg        <= MEM_RATE_RSVD;
      end else if (ce) begin
         if (clk_sync_done) begin
            mem_freq_active_reg <= mem_freq_select_reg;
         end
         unique case ({strap_reg.bus_speed_strap, mem_freq_active_reg})
            {FBF_533, MFS_333}: mem_rate_reg <= MEM_RATE_333;
            {FBF_800, MFS_333}: mem_rate_reg <= MEM_RATE_320;
            {FBF_800, MFS_400}: mem_rate_reg <= MEM_RATE_400;
            default:            mem_rate_reg <= MEM_RATE_RSVD;
         endcase
      end
   end

   assign mem_rate    = mem_rate_reg;
   assign mem_io_mult = MEM_IO_MULT;

   // per-lane compatibility decode, A15:10 ignored
   logic [3:0] lane_mono;
   logic [3:0] lane_3bf;
   logic [3:0] lane_vga;

   for (genvar lane = 0; lane < 4; lane++) begin : g_lane
      logic [9:0] port;
      assign port = {cpu_req.addr[9:2], 2'(lane)};
      assign lane_mono[lane] = cpu_req.byte_en[lane] &&
         (port == PORT_3B4 || port == PORT_3B5 || port == PORT_3B8 ||
          port == PORT_3B9 || port == PORT_3BA || port == PORT_3BF);
      assign lane_3bf[lane] = cpu_req.byte_en[lane] && (port == PORT_3BF);
      assign lane_vga[lane] = cpu_req.byte_en[lane] &&
         ((port >= VGA_IO_A_LO && port <= VGA_IO_A_HI) ||
          (port >= VGA_IO_B_LO && port <= VGA_IO_B_HI));
   end

   logic io_mono;
   logic io_3bf;
   logic io_vga;
   logic io_3bc_dw;
   logic io_window;
   logic mem_mono;
   logic mem_vga;
   logic to_gfx;

   assign io_mono   = |lane_mono;
   assign io_3bf    = |lane_3bf;
   assign io_vga    = |lane_vga;
   assign io_3bc_dw = (cpu_req.addr[9:2] == DW_3BC);
   // isa enable drops the upper three quarters of each 1 KB block
   assign io_window = (cpu_req.addr[15:0] >= bridge_control.bridge_io_base) &&
                      (cpu_req.addr[15:0] <= bridge_control.bridge_io_limit) &&
                      !(bridge_control.isa_enable && cpu_req.addr[9:8] != 2'h0);
   assign mem_mono  = (cpu_req.addr >= MONO_MEM_LO) && (cpu_req.addr <= MONO_MEM_HI);
   assign mem_vga   = (cpu_req.addr >= VGA_MEM_LO) && (cpu_req.addr <= VGA_MEM_HI);

   // mono-present with vga clear is illegal; it decodes as vga clear
   always_comb begin
      to_gfx = 1'b0;
      if (cpu_req.is_io) begin
         if (!bridge_control.vga_enable) begin
            if (io_3bc_dw) begin
               to_gfx = io_window;
            end else if (io_mono || io_vga) begin
               to_gfx = 1'b0;
            end else begin
               to_gfx = io_window;
            end
         end else if (mono_adapter_present_reg) begin
            if (io_mono) begin
               to_gfx = 1'b0;
            end else if (io_vga) begin
               to_gfx = 1'b1;
            end else begin
               to_gfx = io_window;
            end
         end else begin
            if (io_3bf) begin
               to_gfx = 1'b0;
            end else if (io_vga || io_mono) begin
               to_gfx = 1'b1;
            end else begin
               to_gfx = io_window;
            end
         end
      end else if (mem_mono) begin
         to_gfx = bridge_control.vga_enable && !mono_adapter_present_reg;
      end else if (mem_vga) begin
         to_gfx = bridge_control.vga_enable;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         route_valid_reg <= 1'b0;
         route_gfx_reg   <= 1'b0;
      end else if (ce) begin
         route_valid_reg <= cpu_req.valid;
         if (cpu_req.valid) begin
            route_gfx_reg <= to_gfx;
         end
      end
   end

   assign route_valid       = route_valid_reg;
   assign route_to_graphics = route_gfx_reg;

   // error flags: set wins over a same-cycle write-one clear
   always_comb begin
      err_events                  = 16'h0000;
      err_events[NONMEM_LOCK_BIT] = err_event.nonmem_lock;
      err_events[SW_MGMT_BIT]     = err_event.sw_mgmt;
      err_events[MULTI_BIT]       = ecc_report.multi;
      err_events[SPECIAL_BIT]     = err_event.special_cycle;
      err_events[OUTSIDE_AP_BIT]  = err_event.outside_aperture;
      err_events[INVALID_GFX_BIT] = err_event.invalid_gfx;
      err_events[BAD_ENTRY_BIT]   = err_event.bad_entry;
      err_events[UNSUP_CMD_BIT]   = err_event.unsup_cmd;
      err_events[SINGLE_BIT]      = ecc_report.single;
   end

   assign err_clear      = (wr_access && hit_err) ? pwdata[15:0] : 16'h0000;
   assign err_flags_next = ((err_flags_reg & ~err_clear) | err_events) & ERR_STS_MASK;
   assign err_rise       = err_events & ~err_flags_reg & ERR_STS_MASK;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_flags_reg <= ERR_STS_RESET;
         serr_msg_reg  <= 1'b0;
      end else if (ce) begin
         err_flags_reg <= err_flags_next;
         serr_msg_reg  <= serr_global_enable && |(err_rise & error_command);
      end
   end

   assign serr_msg = serr_msg_reg;

   // log locks on a multi-bit error; a single-bit lock yields to multi-bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         log_reg <= '0;
      end else if (ce) begin
         if (ecc_report.multi && !err_flags_reg[MULTI_BIT]) begin
            log_reg.addr                 <= ecc_report.addr;
            log_reg.channel              <= ecc_report.channel;
            log_reg.device               <= ecc_report.device;
            log_reg.multi_error_log_flag <= err_flags_reg[SINGLE_BIT];
         end else if (ecc_report.single && !err_flags_reg[SINGLE_BIT] &&
                      !err_flags_reg[MULTI_BIT]) begin
            log_reg.addr                 <= ecc_report.addr;
            log_reg.channel              <= ecc_report.channel;
            log_reg.device               <= ecc_report.device;
            log_reg.multi_error_log_flag <= 1'b0;
         end
      end
   end

   assign error_address_log = log_reg;

endmodule : host_bridge_config_and_error_status

// File: host_bridge_config_and_error_status_tb.sv
// self-checking bench for the hub configuration and error status bank
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps

module host_bridge_config_and_error_status_tb;
   import host_bridge_pkg::*;
   logic              clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, slv;
   logic              power_good, fsb_stop_grant, stop_grant_ack, clk_sync_done, hit;
   logic              route_valid, route_to_graphics, serr_global_enable, serr_msg;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, a;
   logic [15:0]       error_command;
   logic [3:0]        queue_depth;
   logic [1:0]        mem_io_mult, prev;
   mem_rate_t         mem_rate;
   straps_t           straps, s;
   bridge_control_t   bridge_control;
   cpu_req_t          cpu_req;
   err_event_t        err_event;
   ecc_report_t       ecc_report;
   err_log_t          error_address_log;
   int                n_errors, check_count, hits;
   int                bits [7] = '{1, 2, 3, 4, 5, 8, 9};

   host_bridge_config_and_error_status i_dut (.*);

   task automatic check(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   // holds the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic sg(input int n);
      repeat (n) @(posedge clk) fsb_stop_grant <= 1'b1;
      @(posedge clk) fsb_stop_grant <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : sg

   task automatic ecc(input logic m, sb, input logic [31:0] ad);
      @(posedge clk) ecc_report <= {m, sb, ad, 1'b1, 3'h5};
      @(posedge clk) ecc_report <= '0;
      #1;
   endtask : ecc

   task automatic rt(input logic io, input logic [31:0] ad, input logic [3:0] be, input logic e);
      @(posedge clk) cpu_req <= {1'b1, io, ad, be};
      @(posedge clk) cpu_req <= '0;
      #1 check("route valid", 32'h1, {31'h0, route_valid});
      check("route target", {31'h0, e}, {31'h0, route_to_graphics});
   endtask : rt

   function automatic logic [1:0] exp_rate(input logic [1:0] f, sel);
      if (f == FBF_533 && sel == MFS_333) return MEM_RATE_333;
      if (f == FBF_800 && sel == MFS_333) return MEM_RATE_320;
      if (f == FBF_800 && sel == MFS_400) return MEM_RATE_400;
      return MEM_RATE_RSVD;
   endfunction : exp_rate

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) if (stop_grant_ack === 1'b1) hits++;

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end

   initial begin
      void'($urandom(32'h7091));
      {psel, penable, pwrite, paddr, pwdata, fsb_stop_grant, clk_sync_done} = '0;
      {rst_b, power_good, cpu_req, err_event, ecc_report, prev} = '0;
      {ce, serr_global_enable, error_command} = {2'b11, 16'hffff};
      bridge_control = {2'b00, 16'h0000, 16'hffff};
      straps = {1'b1, 1'($urandom), 2'(1 + $urandom % 2)};
      s = straps;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk) power_good <= 1'b1;
      repeat (3) @(posedge clk) straps <= ~s;
      apb(0, HUB_CFG_ADDR, 32'h0);
      check("cfg straps", {28'h0, s}, rd);
      check("queue depth", s.queue_depth_pin ? IOQ_DEEP : IOQ_SHALLOW, queue_depth);
      check("io multiple", 32'h2, mem_io_mult);
      apb(1, HUB_CFG_ADDR, 32'hffffffff);
      apb(0, HUB_CFG_ADDR, 32'h0);
      check("cfg mask", {16'h0, HUB_CFG_WMASK} | s, rd);
      for (int i = 0; i < 4; i++) begin
         apb(1, HUB_CFG_ADDR, {16'h0, SGC_TWO, 1'b0, 2'(i), 10'h0});
         repeat (3) @(posedge clk);
         check("rate before sync", prev, mem_rate);
         @(posedge clk) clk_sync_done <= 1'b1;
         @(posedge clk) clk_sync_done <= 1'b0;
         repeat (2) @(posedge clk);
         prev = exp_rate(s.bus_speed_strap, 2'(i));
         #1 check("rate after sync", prev, mem_rate);
      end
      hits = 0;
      sg(4);
      check("acks per two", 32'd2, hits);
      apb(1, HUB_CFG_ADDR, {16'h0, SGC_ONE, 13'h0});
      sg(3);
      check("acks per one", 32'd5, hits);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk) {err_event, serr_global_enable} <= {err_event_t'(7'(1 << i)), i[0]};
         @(posedge clk) err_event <= '0;
         #1 hit = serr_msg;
         @(posedge clk) #1 hit = hit | serr_msg;
         check("error message", {31'h0, i[0]}, {31'h0, hit});
         apb(1, ERR_STS_ADDR, 32'hffff0000);
         apb(0, ERR_STS_ADDR, 32'h0);
         check("flag set", 32'h1 << bits[i], rd);
         apb(1, ERR_STS_ADDR, 32'h1 << bits[i]);
         apb(0, ERR_STS_ADDR, 32'h0);
         check("flag cleared", 32'h0, rd);
      end
      a = $urandom;
      ecc(0, 1, a);
      ecc(0, 1, ~a);
      check("single log locked", a, error_address_log.addr);
      check("log source", 32'hd, error_address_log[4:1]);
      ecc(1, 0, a ^ 32'h55);
      ecc(1, 0, a ^ 32'haa);
      check("multi overwrites", a ^ 32'h55, error_address_log.addr);
      check("multi after single", 32'h1, error_address_log.multi_error_log_flag);
      apb(0, ERR_STS_ADDR, 32'h0);
      check("ecc flags", 32'h81, rd);
      apb(1, ERR_STS_ADDR, 32'h80);
      ecc(1, 0, ~a);
      check("log unlocked", ~a, error_address_log.addr);
      apb(0, 12'h000, 32'h0);
      check("unmapped data", 32'h0, rd);
      check("unmapped slverr", 32'h1, {31'h0, slv});
      rt(0, 32'h000b0000, 4'hf, 0);
      rt(1, 32'h000003b4, 4'h1, 0);
      rt(1, 32'h000003bc, 4'h8, 1);
      @(posedge clk) bridge_control.isa_enable <= 1'b1;
      rt(1, 32'h000003bc, 4'h8, 0);
      @(posedge clk) bridge_control <= {2'b10, 16'h0000, 16'hffff};
      rt(0, 32'h000b1000, 4'hf, 1);
      rt(1, 32'h000003bc, 4'h8, 0);
      rt(1, 32'h000003b4, 4'h1, 1);
      apb(1, HUB_CFG_ADDR, 32'h20);
      rt(0, 32'h000b0000, 4'hf, 0);
      rt(0, 32'h000a0000, 4'hf, 1);
      rt(1, 32'h000007b4, 4'h1, 0);
      rt(1, 32'h000003b8, 4'hf, 0);
      rt(0, 32'h00100000 + $urandom % 32'h10000000, 4'hf, 0);
      @(posedge clk) ce <= 1'b0;
      @(posedge clk) #1 check("ready follows enable", 32'h0, {31'h0, pready});
      @(posedge clk) ce <= 1'b1;
      final_report();
   end
endmodule : host_bridge_config_and_error_status_tb

// File: host_bridge_pkg.sv
// constants, field layout and carrier types for the host bridge config/error bank
// assumes a 32-bit APB master; register indices scale by four to byte addresses
package host_bridge_pkg;

   localparam int unsigned ADDR_W = 12;

   // printed offsets are not word multiples, so they are indices
   localparam logic [7:0]        HUB_CFG_IDX  = 8'hc6;
   localparam logic [7:0]        ERR_STS_IDX  = 8'hc8;
   localparam logic [ADDR_W-1:0] HUB_CFG_ADDR = {2'h0, HUB_CFG_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] ERR_STS_ADDR = {2'h0, ERR_STS_IDX, 2'h0};

   localparam logic [15:0] HUB_CFG_RESET = 16'h0000;
   localparam logic [15:0] ERR_STS_RESET = 16'h0000;
   localparam logic [15:0] HUB_CFG_WMASK = 16'hec20;
   localparam logic [15:0] ERR_STS_MASK  = 16'h03bf;

   // hub_configuration fields
   localparam int unsigned SGC_HI    = 15;
   localparam int unsigned SGC_LO    = 13;
   localparam int unsigned MFS_HI    = 11;
   localparam int unsigned MFS_LO    = 10;
   localparam int unsigned MONO_BIT  = 5;
   localparam int unsigned GMODE_BIT = 3;
   localparam int unsigned IOQ_BIT   = 2;
   localparam int unsigned FBF_HI    = 1;
   localparam int unsigned FBF_LO    = 0;

   // error_status flag positions
   localparam int unsigned NONMEM_LOCK_BIT = 9;
   localparam int unsigned SW_MGMT_BIT     = 8;
   localparam int unsigned MULTI_BIT       = 7;
   localparam int unsigned SPECIAL_BIT     = 5;
   localparam int unsigned OUTSIDE_AP_BIT  = 4;
   localparam int unsigned INVALID_GFX_BIT = 3;
   localparam int unsigned BAD_ENTRY_BIT   = 2;
   localparam int unsigned UNSUP_CMD_BIT   = 1;
   localparam int unsigned SINGLE_BIT      = 0;

   localparam logic [2:0] SGC_ONE = 3'h0;
   localparam logic [2:0] SGC_TWO = 3'h1;
   localparam logic [1:0] FBF_533 = 2'h1;
   localparam logic [1:0] FBF_800 = 2'h2;
   localparam logic [1:0] MFS_333 = 2'h1;
   localparam logic [1:0] MFS_400 = 2'h2;
   localparam logic [3:0] IOQ_SHALLOW = 4'h1;
   localparam logic [3:0] IOQ_DEEP    = 4'hc;
   localparam logic [1:0] MEM_IO_MULT = 2'h2;

   // compatibility decode
   localparam logic [9:0]  PORT_3B4 = 10'h3b4;
   localparam logic [9:0]  PORT_3B5 = 10'h3b5;
   localparam logic [9:0]  PORT_3B8 = 10'h3b8;
   localparam logic [9:0]  PORT_3B9 = 10'h3b9;
   localparam logic [9:0]  PORT_3BA = 10'h3ba;
   localparam logic [9:0]  PORT_3BF = 10'h3bf;
   localparam logic [9:0]  VGA_IO_A_LO = 10'h3b0;
   localparam logic [9:0]  VGA_IO_A_HI = 10'h3bb;
   localparam logic [9:0]  VGA_IO_B_LO = 10'h3c0;
   localparam logic [9:0]  VGA_IO_B_HI = 10'h3df;
   localparam logic [7:0]  DW_3BC      = 8'hef;
   localparam logic [31:0] MONO_MEM_LO = 32'h000b0000;
   localparam logic [31:0] MONO_MEM_HI = 32'h000b7fff;
   localparam logic [31:0] VGA_MEM_LO  = 32'h000a0000;
   localparam logic [31:0] VGA_MEM_HI  = 32'h000bffff;

   typedef enum logic [1:0] {
      MEM_RATE_RSVD = 2'h0,
      MEM_RATE_333  = 2'h1,
      MEM_RATE_320  = 2'h3,
      MEM_RATE_400  = 2'h2
   } mem_rate_t;

   typedef struct packed {
      logic       graphics_mode_strap;
      logic       queue_depth_pin;
      logic [1:0] bus_speed_strap;
   } straps_t;

   typedef struct packed {
      logic nonmem_lock;
      logic sw_mgmt;
      logic special_cycle;
      logic outside_aperture;
      logic invalid_gfx;
      logic bad_entry;
      logic unsup_cmd;
   } err_event_t;

   typedef struct packed {
      logic        multi;
      logic        single;
      logic [31:0] addr;
      logic        channel;
      logic [2:0]  device;
   } ecc_report_t;

   typedef struct packed {
      logic [31:0] addr;
      logic        channel;
      logic [2:0]  device;
      logic        multi_error_log_flag;
   } err_log_t;

   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic [31:0] addr;
      logic [3:0]  byte_en;
   } cpu_req_t;

   typedef struct packed {
      logic        vga_enable;
      logic        isa_enable;
      logic [15:0] bridge_io_base;
      logic [15:0] bridge_io_limit;
   } bridge_control_t;

endpackage : host_bridge_pkg
